// *** pkg/risc_exec_defs.svh ***
// Purpose: constants for the instruction execute block
// Assumes: 12-bit instruction words, 32 file registers, 8-bit data
// Notes:   opcode patterns use ? for operand fields
`ifndef RISC_EXEC_DEFS_SVH
`define RISC_EXEC_DEFS_SVH
`define FA_TIMER     5'h01
`define FA_PCL       5'h02
`define FA_STATUS    5'h03
`define ST_C         0
`define ST_DC        1
`define ST_Z         2
`define ST_PD        3
`define ST_TO        4
`define OPT_PSA      3
`define DIRECTION_LATCH_LOAD_PORT    3'h6
`define STATUS_RST   8'h18
`define OPTION_RST   8'hFF
`define DIR_RST      8'hFF
`define PC_RST       11'h7FF
`define OPC_NOP      12'b0000_0000_0000
`define OPC_OPTION   12'b0000_0000_0010
`define OPC_SLEEP    12'b0000_0000_0011
`define OPC_CLEAR_WATCHDOG   12'b0000_0000_0100
`define OPC_CLEAR_WORKING     12'b0000_0100_0000
`define OPC_DIRECTION_LATCH_LOAD     12'b0000_0000_0???
`define OPC_STORE_WORKING    12'b0000_001?_????
`define OPC_SUBTRACT_WORKING    12'b0000_10??_????
`define OPC_DECREMENT_REGISTER     12'b0000_11??_????
`define OPC_OR_REGISTER    12'b0001_00??_????
`define OPC_XOR_REGISTER    12'b0001_10??_????
`define OPC_MOVE_REGISTER     12'b0010_00??_????
`define OPC_COMPLEMENT_REGISTER     12'b0010_01??_????
`define OPC_INCREMENT_REGISTER     12'b0010_10??_????
`define OPC_DECREMENT_SKIP_ZERO   12'b0010_11??_????
`define OPC_RRF      12'b0011_00??_????
`define OPC_RLF      12'b0011_01??_????
`define OPC_SWAP_NIBBLES    12'b0011_10??_????
`define OPC_INCREMENT_SKIP_ZERO   12'b0011_11??_????
`define OPC_RETURN_WITH_LITERAL    12'b1000_????_????
`define OPC_JUMP_IMMEDIATE     12'b101?_????_????
`define OPC_MOVE_LITERAL    12'b1100_????_????
`define OPC_OR_LITERAL    12'b1101_????_????
`define OPC_XOR_LITERAL    12'b1111_????_????
`endif

// *** pkg/risc_exec_pkg.sv ***
// Purpose: types for the instruction execute block
// Assumes: nothing
// Notes:   none
package risc_exec_pkg;
  typedef enum logic [4:0] {
    OP_NOP, OP_CLEAR_WORKING, OP_CLEAR_WATCHDOG, OP_SLEEP, OP_OPTION, OP_DIRECTION_LATCH_LOAD, OP_STORE_WORKING,
    OP_SUBTRACT_WORKING, OP_DECREMENT_REGISTER, OP_OR_REGISTER, OP_XOR_REGISTER, OP_MOVE_REGISTER, OP_COMPLEMENT_REGISTER, OP_INCREMENT_REGISTER,
    OP_DECREMENT_SKIP_ZERO, OP_RRF, OP_RLF, OP_SWAP_NIBBLES, OP_INCREMENT_SKIP_ZERO, OP_RETURN_WITH_LITERAL, OP_JUMP_IMMEDIATE,
    OP_MOVE_LITERAL, OP_OR_LITERAL, OP_XOR_LITERAL
  } op_t;
  typedef enum logic [1:0] {
    ST_RUN   = 2'b01,
    ST_SLEEP = 2'b10
  } run_state_t;
  typedef struct packed {
    op_t        op;
    logic       dest;
    logic [4:0] fa;
    logic [7:0] lit;
  } dec_t;
endpackage

// *** src/risc_instruction_execute.sv ***
// Purpose: decode and execute of the second half of a 12-bit instruction set
// Assumes: program memory answers prog_addr_o combinationally on prog_data_i
// Notes:   one instruction per cycle; branches and taken skips flush the prefetch
`timescale 1ns/100ps
`include "risc_exec_defs.svh"
module risc_instruction_execute
  import risc_exec_pkg::*;
#(
  parameter int WDT_W = 8,
  parameter int PRE_W = 8
) (
  input  wire logic             sys_clk_i,
  input  wire logic             reset_i,
  input  wire logic [11:0]      prog_data_i,
  input  wire logic [10:0]      stack_top_i,
  input  wire logic             wake_pin_i,
  output logic      [10:0]      prog_addr_o,
  output logic                  stack_pop_o,
  output logic      [7:0]       working_o,
  output logic      [7:0]       status_o,
  output logic      [7:0]       option_o,
  output logic      [7:0]       pin_oe_n_o,
  output logic      [WDT_W-1:0] watchdog_counter_o,
  output logic      [PRE_W-1:0] prescaler_o,
  output logic                  osc_stop_o
);

  ////////////////////////////////////////////////////////////////////////////
  logic [10:0]      pc_q;
  logic [11:0]      ir_q;
  logic             flush_q;
  logic [7:0]       w_q;
  logic [7:0]       status_q;
  logic [7:0]       opt_q;
  logic [7:0]       dir_q;
  logic [7:0]       file_q [32];
  logic [WDT_W-1:0] wdt_q;
  logic [PRE_W-1:0] pre_q;
  logic             pop_q;
  logic [1:0]       wake_sync_q;
  logic             wake_last_q;
  run_state_t       state_q;
  dec_t             dec;
  logic             ex;
  logic [7:0]       fv;
  logic [7:0]       res;
  logic             rt;
  logic             to_w;
  logic             to_f;
  logic             z_en;
  logic             c_en;
  logic             c_new;
  logic             dc_en;
  logic             dc_new;
  logic             skip;
  logic             jump;
  logic [10:0]      jt;
  logic [8:0]       sum9;
  logic [4:0]       sum5;
  logic             pre_clr;

  assign ex = (state_q == ST_RUN) && !flush_q;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  always_comb begin
    dec.dest = ir_q[5];
    dec.fa   = ir_q[4:0];
    dec.lit  = ir_q[7:0];
    casez (ir_q)
      `OPC_NOP:    dec.op = OP_NOP;
      `OPC_OPTION: dec.op = OP_OPTION;
      `OPC_SLEEP:  dec.op = OP_SLEEP;
      `OPC_CLEAR_WATCHDOG: dec.op = OP_CLEAR_WATCHDOG;
      `OPC_CLEAR_WORKING:   dec.op = OP_CLEAR_WORKING;
      `OPC_DIRECTION_LATCH_LOAD:   dec.op = OP_DIRECTION_LATCH_LOAD;
      `OPC_STORE_WORKING:  dec.op = OP_STORE_WORKING;
      `OPC_SUBTRACT_WORKING:  dec.op = OP_SUBTRACT_WORKING;
      `OPC_DECREMENT_REGISTER:   dec.op = OP_DECREMENT_REGISTER;
      `OPC_OR_REGISTER:  dec.op = OP_OR_REGISTER;
      `OPC_XOR_REGISTER:  dec.op = OP_XOR_REGISTER;
      `OPC_MOVE_REGISTER:   dec.op = OP_MOVE_REGISTER;
      `OPC_COMPLEMENT_REGISTER:   dec.op = OP_COMPLEMENT_REGISTER;
      `OPC_INCREMENT_REGISTER:   dec.op = OP_INCREMENT_REGISTER;
      `OPC_DECREMENT_SKIP_ZERO: dec.op = OP_DECREMENT_SKIP_ZERO;
      `OPC_RRF:    dec.op = OP_RRF;
      `OPC_RLF:    dec.op = OP_RLF;
      `OPC_SWAP_NIBBLES:  dec.op = OP_SWAP_NIBBLES;
      `OPC_INCREMENT_SKIP_ZERO: dec.op = OP_INCREMENT_SKIP_ZERO;
      `OPC_RETURN_WITH_LITERAL:  dec.op = OP_RETURN_WITH_LITERAL;
      `OPC_JUMP_IMMEDIATE:   dec.op = OP_JUMP_IMMEDIATE;
      `OPC_MOVE_LITERAL:  dec.op = OP_MOVE_LITERAL;
      `OPC_OR_LITERAL:  dec.op = OP_OR_LITERAL;
      `OPC_XOR_LITERAL:  dec.op = OP_XOR_LITERAL;
      default:     dec.op = OP_NOP;
    endcase
  end

  // operand read; pc low reads the fetch address
  always_comb begin
    case (dec.fa)
      `FA_PCL:    fv = pc_q[7:0];
      `FA_STATUS: fv = status_q;
      default:    fv = file_q[dec.fa];
    endcase
  end

  assign sum9 = {1'b0, fv} + {1'b0, ~w_q} + 9'h001;
  assign sum5 = {1'b0, fv[3:0]} + {1'b0, ~w_q[3:0]} + 5'h01;

  ////////////////////////////////////////////////////////////////////////////
  // execute
  always_comb begin
    res    = fv;
    rt     = 1'b0;
    to_w   = 1'b0;
    to_f   = 1'b0;
    z_en   = 1'b0;
    c_en   = 1'b0;
    c_new  = status_q[`ST_C];
    dc_en  = 1'b0;
    dc_new = status_q[`ST_DC];
    skip   = 1'b0;
    case (dec.op)
      OP_CLEAR_WORKING:   begin res = 8'h00; to_w = 1'b1; z_en = 1'b1; end
      OP_STORE_WORKING:  begin res = w_q; to_f = 1'b1; end
      OP_SUBTRACT_WORKING:  begin
        res = sum9[7:0]; rt = 1'b1; z_en = 1'b1;
        c_en = 1'b1; c_new = sum9[8]; dc_en = 1'b1; dc_new = sum5[4];
      end
      OP_DECREMENT_REGISTER:   begin res = fv - 8'h01; rt = 1'b1; z_en = 1'b1; end
      OP_OR_REGISTER:  begin res = fv | w_q; rt = 1'b1; z_en = 1'b1; end
      OP_XOR_REGISTER:  begin res = fv ^ w_q; rt = 1'b1; z_en = 1'b1; end
      OP_MOVE_REGISTER:   begin rt = 1'b1; z_en = 1'b1; end
      OP_COMPLEMENT_REGISTER:   begin res = ~fv; rt = 1'b1; z_en = 1'b1; end
      OP_INCREMENT_REGISTER:   begin res = fv + 8'h01; rt = 1'b1; z_en = 1'b1; end
      OP_DECREMENT_SKIP_ZERO: begin
        res = fv - 8'h01; rt = 1'b1; skip = (res == 8'h00);
      end
      OP_INCREMENT_SKIP_ZERO: begin
        res = fv + 8'h01; rt = 1'b1; skip = (res == 8'h00);
      end
      OP_RRF:    begin
        res = {status_q[`ST_C], fv[7:1]}; rt = 1'b1; c_en = 1'b1; c_new = fv[0];
      end
      OP_RLF:    begin
        res = {fv[6:0], status_q[`ST_C]}; rt = 1'b1; c_en = 1'b1; c_new = fv[7];
      end
      OP_SWAP_NIBBLES:  begin res = {fv[3:0], fv[7:4]}; rt = 1'b1; end
      OP_RETURN_WITH_LITERAL,
      OP_MOVE_LITERAL:  begin res = dec.lit; to_w = 1'b1; end
      OP_OR_LITERAL:  begin res = w_q | dec.lit; to_w = 1'b1; z_en = 1'b1; end
      OP_XOR_LITERAL:  begin res = w_q ^ dec.lit; to_w = 1'b1; z_en = 1'b1; end
      default:   begin res = fv; end
    endcase
    if (rt) begin
      to_w = !dec.dest;
      to_f = dec.dest;
    end
  end

  // pc writers; bit 8 forced low except on the jump
  always_comb begin
    jump = 1'b0;
    jt   = pc_q;
    if (dec.op == OP_JUMP_IMMEDIATE) begin
      jump = 1'b1;
      jt   = {status_q[6:5], ir_q[8:0]};
    end else if (dec.op == OP_RETURN_WITH_LITERAL) begin
      jump = 1'b1;
      jt   = {stack_top_i[10:9], 1'b0, stack_top_i[7:0]};
    end else if (to_f && dec.fa == `FA_PCL) begin
      jump = 1'b1;
      jt   = {status_q[6:5], 1'b0, res};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fetch, flush and sleep
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pc_q    <= `PC_RST;
      ir_q    <= 12'h000;
      flush_q <= 1'b1;
      state_q <= ST_RUN;
    end else if (state_q == ST_RUN) begin
      ir_q    <= prog_data_i;
      pc_q    <= pc_q + 11'h001;
      flush_q <= 1'b0;
      if (ex && jump) begin
        pc_q    <= jt;
        flush_q <= 1'b1;
      end else if (ex && skip) begin
        flush_q <= 1'b1;
      end
      if (ex && dec.op == OP_SLEEP) begin
        state_q <= ST_SLEEP;
        flush_q <= 1'b1;
      end
    end else if (wake_sync_q[1] && !wake_last_q) begin
      state_q <= ST_RUN;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wake_sync_q <= 2'b00;
      wake_last_q <= 1'b0;
    end else begin
      wake_sync_q <= {wake_sync_q[0], wake_pin_i};
      wake_last_q <= wake_sync_q[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  always_ff @(posedge sys_clk_i) begin
    if (ex && to_f && dec.fa != `FA_PCL && dec.fa != `FA_STATUS) begin
      file_q[dec.fa] <= res;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      w_q <= 8'h00;
    end else if (ex && to_w) begin
      w_q <= res;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      status_q <= `STATUS_RST;
    end else if (ex) begin
      if (to_f && dec.fa == `FA_STATUS) begin
        status_q <= {res[7:5], status_q[`ST_TO], status_q[`ST_PD], res[2:0]};
      end
      if (z_en)  status_q[`ST_Z]  <= (res == 8'h00);
      if (c_en)  status_q[`ST_C]  <= c_new;
      if (dc_en) status_q[`ST_DC] <= dc_new;
      if (dec.op == OP_CLEAR_WATCHDOG) begin
        status_q[`ST_TO] <= 1'b1;
        status_q[`ST_PD] <= 1'b1;
      end
      if (dec.op == OP_SLEEP) begin
        status_q[`ST_TO] <= 1'b1;
        status_q[`ST_PD] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      opt_q <= `OPTION_RST;
      dir_q <= `DIR_RST;
      pop_q <= 1'b0;
    end else begin
      pop_q <= ex && dec.op == OP_RETURN_WITH_LITERAL;
      if (ex && dec.op == OP_OPTION) opt_q <= w_q;
      if (ex && dec.op == OP_DIRECTION_LATCH_LOAD && ir_q[2:0] == `DIRECTION_LATCH_LOAD_PORT) begin
        dir_q <= w_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog and shared prescaler
  always_comb begin
    pre_clr = 1'b0;
    if (ex && dec.op == OP_CLEAR_WATCHDOG && opt_q[`OPT_PSA]) pre_clr = 1'b1;
    if (ex && dec.op == OP_SLEEP) pre_clr = 1'b1;
    if (ex && to_f && dec.fa == `FA_TIMER && !opt_q[`OPT_PSA]) begin
      pre_clr = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      wdt_q <= '0;
      pre_q <= '0;
    end else begin
      wdt_q <= wdt_q + 1'b1;
      pre_q <= pre_q + 1'b1;
      if (ex && (dec.op == OP_CLEAR_WATCHDOG || dec.op == OP_SLEEP)) wdt_q <= '0;
      if (pre_clr) pre_q <= '0;
    end
  end

  assign prog_addr_o        = pc_q;
  assign stack_pop_o        = pop_q;
  assign working_o          = w_q;
  assign status_o           = status_q;
  assign option_o           = opt_q;
  assign pin_oe_n_o         = dir_q;
  assign watchdog_counter_o = wdt_q;
  assign prescaler_o        = pre_q;
  assign osc_stop_o         = state_q[1];

  ////////////////////////////////////////////////////////////////////////////
  a_clear_working_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ex && dec.op == OP_CLEAR_WORKING |=> w_q == 8'h00 && status_q[`ST_Z])
    else $error("clear working did not zero W and set zero");
  a_wdt_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ex && dec.op == OP_CLEAR_WATCHDOG |=> wdt_q == '0 && status_q[`ST_TO] && status_q[`ST_PD])
    else $error("watchdog clear wrong");
  a_skip_flush: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ex && dec.op == OP_DECREMENT_SKIP_ZERO && fv == 8'h01 |=> flush_q ##1 !flush_q)
    else $error("taken skip did not discard one word");
  a_jump_target: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ex && dec.op == OP_JUMP_IMMEDIATE |=> pc_q == {$past(status_q[6:5]), $past(ir_q[8:0])} && flush_q)
    else $error("jump target wrong");
  a_increment_skip_zero_flags: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ex && dec.op == OP_INCREMENT_SKIP_ZERO && !(dec.dest && dec.fa == `FA_STATUS)
    |=> $stable(status_q))
    else $error("increment skip changed flags");
  a_or_literal: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ex && dec.op == OP_OR_LITERAL |=> w_q == ($past(w_q) | $past(ir_q[7:0])))
    else $error("or literal result wrong");
  a_swap_w: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ex && dec.op == OP_SWAP_NIBBLES && !dec.dest |=> w_q == {$past(fv[3:0]), $past(fv[7:4])})
    else $error("swap result wrong");
  a_dir_load: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ex && dec.op == OP_DIRECTION_LATCH_LOAD && ir_q[2:0] == `DIRECTION_LATCH_LOAD_PORT |=> pin_oe_n_o == $past(w_q))
    else $error("direction latches not loaded from W");
  a_pc_bit8: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ex && jump && dec.op != OP_JUMP_IMMEDIATE |=> !pc_q[8])
    else $error("pc bit 8 not cleared");
  a_sleep_flags: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ex && dec.op == OP_SLEEP |=> osc_stop_o && status_q[`ST_TO] && !status_q[`ST_PD])
    else $error("sleep entry wrong");

endmodule

// *** verif/prog_mem_model.sv ***
// Purpose: program memory on the far side of the execute block
// Assumes: the word at the fetch address is answered in the same cycle
// Notes:   the bench loads programs through the words array
`timescale 1ns/100ps
module prog_mem_model (
  input  wire logic [10:0] addr_i,
  output logic      [11:0] data_o
);
  logic [11:0] words [0:2047];

  // untouched words read as no-operation
  initial begin
    for (int i = 0; i < 2048; i++) begin
      words[i] = 12'h000;
    end
  end

  assign data_o = words[addr_i];
endmodule

// *** verif/risc_instruction_execute_bench.sv ***
// Purpose: self-checking bench for the instruction execute block
// Assumes: default counter widths; programs end in a jump to itself
// Notes:   each scenario loads a program, resets the block and inspects results
`timescale 1ns/100ps
module risc_instruction_execute_bench;
  import risc_exec_pkg::*;

  logic        sys_clk_i;
  logic        reset_i;
  logic [11:0] prog_data;
  logic [10:0] stack_top_i;
  logic        wake_pin_i;
  logic [10:0] prog_addr_o;
  logic        stack_pop_o;
  logic [7:0]  working_o;
  logic [7:0]  status_o;
  logic [7:0]  option_o;
  logic [7:0]  pin_oe_n_o;
  logic [7:0]  watchdog_counter_o;
  logic [7:0]  prescaler_o;
  logic        osc_stop_o;
  int          errors;
  int          samples_checked;
  int          cycles;
  int          pops;
  int          n;

  risc_instruction_execute risc_instruction_execute_inst (
    .sys_clk_i          (sys_clk_i),
    .reset_i            (reset_i),
    .prog_data_i        (prog_data),
    .stack_top_i        (stack_top_i),
    .wake_pin_i         (wake_pin_i),
    .prog_addr_o        (prog_addr_o),
    .stack_pop_o        (stack_pop_o),
    .working_o          (working_o),
    .status_o           (status_o),
    .option_o           (option_o),
    .pin_oe_n_o         (pin_oe_n_o),
    .watchdog_counter_o (watchdog_counter_o),
    .prescaler_o        (prescaler_o),
    .osc_stop_o         (osc_stop_o)
  );

  prog_mem_model prog_mem_model_inst (
    .addr_i (prog_addr_o),
    .data_o (prog_data)
  );

  initial sys_clk_i = 1'b0;
  always #4 sys_clk_i = ~sys_clk_i;

  always @(negedge sys_clk_i) begin
    if (stack_pop_o === 1'b1) pops++;
  end

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      end_of_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic clr();
    for (int i = 0; i < 2048; i++) prog_mem_model_inst.words[i] = 12'h000;
    n = 0;
  endtask

  task automatic put(input logic [11:0] w);
    prog_mem_model_inst.words[n] = w;
    n++;
  endtask

  task automatic do_reset(input bit show);
    reset_i = 1'b1;
    pops = 0;
    repeat (10) @(negedge sys_clk_i);
    if (show) begin
      chk("pc", 12'h7FF, {1'b0, prog_addr_o});
      chk("w", 12'h000, {4'h0, working_o});
      chk("status", 12'h018, {4'h0, status_o});
      chk("option", 12'h0FF, {4'h0, option_o});
      chk("dir", 12'h0FF, {4'h0, pin_oe_n_o});
      chk("osc", 12'h000, {11'h000, osc_stop_o});
    end
    reset_i = 1'b0;
  endtask

  task automatic wait_addr(input logic [10:0] a);
    int k;
    k = 0;
    while (prog_addr_o !== a && k < 300) begin
      @(negedge sys_clk_i);
      k++;
    end
    if (k == 300) begin
      errors++;
      $display("BAD fetch address expected %h seen %h", a, prog_addr_o);
    end
  endtask

  // appends a jump to itself, then runs the program to it
  task automatic go();
    logic [10:0] h;
    h = n[10:0];
    put(12'hA00 | {3'b000, h[8:0]});
    do_reset(1'b0);
    wait_addr(h);
    repeat (4) @(negedge sys_clk_i);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_literal();
    clr(); put(12'hC9A); put(12'hD35); put(12'hFBF); put(12'hC5A); go();
    chk("w", 12'h05A, {4'h0, working_o});
    chk("zero", 12'h001, {11'h000, status_o[2]});
    clr(); put(12'hC5A); put(12'hD00); put(12'h040); go();
    chk("w", 12'h000, {4'h0, working_o});
    chk("zero", 12'h001, {11'h000, status_o[2]});
  endtask

  task automatic t_dest();
    clr(); put(12'hCFF); put(12'h030); put(12'h2B0); put(12'h0D0);
    put(12'h031); put(12'h230); put(12'h032); go();
    chk("w", 12'h0FF, {4'h0, working_o});
    chk("zero", 12'h001, {11'h000, status_o[2]});
    clr(); put(12'hC01); put(12'h030); put(12'h0F0); put(12'h210); go();
    chk("w", 12'h000, {4'h0, working_o});
    chk("zero", 12'h001, {11'h000, status_o[2]});
  endtask

  task automatic t_skip();
    clr(); put(12'hC01); put(12'h030); put(12'h2F0); put(12'hC77); go();
    chk("w", 12'h001, {4'h0, working_o});
    chk("zero", 12'h000, {11'h000, status_o[2]});
    clr(); put(12'hCFF); put(12'h030); put(12'h3D0); put(12'hF55); go();
    chk("w", 12'h000, {4'h0, working_o});
    chk("zero", 12'h000, {11'h000, status_o[2]});
    clr(); put(12'hC02); put(12'h030); put(12'h2D0); put(12'hF03); go();
    chk("w", 12'h002, {4'h0, working_o});
  endtask

  task automatic t_shift();
    clr(); put(12'hCE6); put(12'h030); put(12'h370); put(12'h310); go();
    chk("w", 12'h0E6, {4'h0, working_o});
    chk("carry", 12'h000, {11'h000, status_o[0]});
    clr(); put(12'hCA5); put(12'h031); put(12'h040); put(12'h3B1); put(12'h391); go();
    chk("w", 12'h0A5, {4'h0, working_o});
    chk("zero", 12'h001, {11'h000, status_o[2]});
    clr(); put(12'hC13); put(12'h030); put(12'h270); put(12'hCEC);
    put(12'h190); put(12'h110); go();
    chk("w", 12'h0EC, {4'h0, working_o});
    chk("flags", 12'h000, {9'h000, status_o[2:0]});
  endtask

  task automatic t_subtract();
    logic [7:0] tf [3] = '{8'h02, 8'h01, 8'h10};
    logic [7:0] tw [3] = '{8'h02, 8'h02, 8'h01};
    logic [7:0] tr [3] = '{8'h00, 8'hFF, 8'h0F};
    logic [2:0] tc [3] = '{3'h7, 3'h0, 3'h1};
    for (int i = 0; i < 3; i++) begin
      clr(); put({4'hC, tf[i]}); put(12'h030); put({4'hC, tw[i]}); put(12'h090); go();
      chk("difference", {4'h0, tr[i]}, {4'h0, working_o});
      chk("flags", {9'h000, tc[i]}, {9'h000, status_o[2:0]});
    end
  endtask

  task automatic t_control();
    clr(); put(12'hCA5); put(12'h006); put(12'hC0F); put(12'h005);
    put(12'hC07); put(12'h002);
    repeat (20) put(12'h000);
    put(12'h021); go();
    chk("dir", 12'h0A5, {4'h0, pin_oe_n_o});
    chk("option", 12'h007, {4'h0, option_o});
    chk("status", 12'h018, {4'h0, status_o});
    chk("prescaler", 12'h001, {11'h000, prescaler_o < 8'h0A});
  endtask

  task automatic t_branch();
    clr(); put(12'hC20); put(12'h023); put(12'hA05);
    n = 5; put(12'hC99);
    n = 12'h205; put(12'hC44); put(12'hA06);
    do_reset(1'b0);
    wait_addr(11'h206);
    repeat (2) @(negedge sys_clk_i);
    chk("w", 12'h044, {4'h0, working_o});
    chk("page", 12'h001, {10'h000, status_o[6:5]});
    clr(); put(12'hB00);
    n = 12'h100; put(12'hC05); put(12'h022);
    n = 12'h105; put(12'hC99);
    n = 5; put(12'hC44); put(12'h83C);
    n = 8; put(12'hA08);
    n = 12'h108; put(12'hC99); put(12'hB08);
    stack_top_i = 11'h108;
    do_reset(1'b0);
    wait_addr(11'h008);
    repeat (4) @(negedge sys_clk_i);
    chk("w", 12'h03C, {4'h0, working_o});
    chk("pops", 12'h001, pops[11:0]);
    chk("status", 12'h018, {4'h0, status_o});
  endtask

  task automatic t_sleep();
    int k;
    logic [10:0] pc;
    clr(); put(12'h003); put(12'h000); put(12'h004); put(12'h000);
    do_reset(1'b0);
    k = 0;
    while (osc_stop_o !== 1'b1 && k < 50) begin
      @(negedge sys_clk_i);
      k++;
    end
    chk("osc", 12'h001, {11'h000, osc_stop_o});
    chk("timeout pd", 12'h002, {10'h000, status_o[4:3]});
    chk("watchdog", 12'h001, {11'h000, watchdog_counter_o < 8'h03});
    chk("prescaler", 12'h001, {11'h000, prescaler_o < 8'h03});
    pc = prog_addr_o;
    repeat (20) @(negedge sys_clk_i);
    chk("held pc", {1'b0, pc}, {1'b0, prog_addr_o});
    wake_pin_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    wake_pin_i = 1'b0;
    put(12'hA04);
    wait_addr(11'h004);
    repeat (2) @(negedge sys_clk_i);
    chk("timeout pd", 12'h003, {10'h000, status_o[4:3]});
    chk("watchdog", 12'h001, {11'h000, watchdog_counter_o < 8'h0A});
    chk("prescaler", 12'h001, {11'h000, prescaler_o < 8'h0A});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_i = 1'b1;
    stack_top_i = 11'h000;
    wake_pin_i = 1'b0;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    pops = 0;
    n = 0;
    @(negedge sys_clk_i);
    do_reset(1'b1);
    t_literal();
    t_dest();
    t_skip();
    t_shift();
    t_subtract();
    t_control();
    t_branch();
    t_sleep();
    end_of_test();
  end
endmodule
